// >>> logic/sac_port.v
// What this block does
// (RULE_01) CS fall resets counters, enables serial port
// (RULE_02) CS rise stops shift clock response
// (RULE_03) Address MSB first, first four rises
// (RULE_04) Eight input bits; address after fourth
// (RULE_05) Output high impedance while CS high
// (RULE_06) CS low drives first previous-result bit
// (RULE_07) Output advances only on falling edges
// (RULE_08) Remaining eleven result bits follow in order
// (RULE_09) Sampling from fourth fall to last
// (RULE_10) Last fall starts internal conversion
// (RULE_11) EOC low until result ready
// (RULE_12) EOC high when conversion completes
// (RULE_13) Fourteen channels: eleven analog, three test
// (RULE_14) Conversion finishes within ten microseconds
// (RULE_15) Host waits CS setup before clocking
//
// Top of the serial converter port; pins sampled on ref_clk.
// Assumes the shift clock is far slower than ref_clk.
`timescale 1ns/1ns
`include "sac_regs.vh"
module sac_port #(
  parameter CONV_CYCLES = `SAC_CONV_CYCLES,
  parameter SETUP_CYCLES = `SAC_CS_SETUP_CYCLES
) (
  input wire ref_clk,
  input wire resetn,
  input wire csN,
  input wire shiftClk,
  input wire dataIn,
  input wire [`SAC_NUM_ANALOG*12-1:0] analogChannelInputs,
  output reg dataOut,
  output reg dataOutEn,
  output reg eocOut,
  output reg sampling,
  output reg [3:0] muxAddr
);
  wire csSync;
  wire sclkSync;
  wire dinSync;
  wire convBusy;
  wire convDone;
  wire [11:0] convResult;
  reg csPrev_r;
  reg sclkPrev_r;
  reg active_r;
  reg [`SAC_SETUP_CNT_W-1:0] setupCnt_r;
  reg [3:0] riseCnt_r;
  reg [3:0] fallCnt_r;
  reg [7:0] inShift_r;
  reg [11:0] outShift_r;
  reg lsbFirst_r;
  reg startConv_r;
  reg [3:0] convChan_r;
  reg [11:0] lastResult_r;
  wire csFall;
  wire csRise;
  wire sclkRise;
  wire sclkFall;
  wire ready;
  wire [11:0] orderedLast;
  // =============================================
  // Pin synchronisers
  sac_sync #(.IDLE(1'b1)) uCs (.ref_clk(ref_clk), .resetn(resetn), .pinIn(csN), .syncOut(csSync));
  sac_sync uClk (.ref_clk(ref_clk), .resetn(resetn), .pinIn(shiftClk), .syncOut(sclkSync));
  sac_sync uDin (.ref_clk(ref_clk), .resetn(resetn), .pinIn(dataIn), .syncOut(dinSync));
  assign csFall = csPrev_r & ~csSync;
  assign csRise = ~csPrev_r & csSync;
  assign ready = active_r && (setupCnt_r == {`SAC_SETUP_CNT_W{1'b0}}); // [RULE_15]
  assign sclkRise = ready && !csSync && !sclkPrev_r && sclkSync; // [RULE_02]
  assign sclkFall = ready && !csSync && sclkPrev_r && !sclkSync; // [RULE_02]
  // =============================================
  // Bit order of the result
  function [11:0] ordered;
    input [11:0] val;
    input lsbFirst;
    integer i;
    begin
      for (i = 0; i < 12; i = i + 1)
        ordered[i] = lsbFirst ? val[11-i] : val[i];
    end
  endfunction
  assign orderedLast = ordered(lastResult_r, lsbFirst_r);
  // =============================================
  // Converter
  sac_conv #(.CONV_CYCLES(CONV_CYCLES)) uConv (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .start(startConv_r), // [RULE_10]
    .chanSel(convChan_r), // [RULE_13]
    .analogIn(analogChannelInputs),
    .busy(convBusy),
    .done(convDone),
    .result(convResult)
  );
  // =============================================
  // Serial frame logic
  always @(posedge ref_clk) begin
    if (!resetn) begin
      csPrev_r <= 1'b1;
      sclkPrev_r <= 1'b0;
      active_r <= 1'b0;
      setupCnt_r <= {`SAC_SETUP_CNT_W{1'b0}};
      riseCnt_r <= 4'h0;
      fallCnt_r <= 4'h0;
      inShift_r <= 8'h00;
      outShift_r <= 12'h000;
      lsbFirst_r <= 1'b0;
      startConv_r <= 1'b0;
      convChan_r <= 4'h0;
      lastResult_r <= 12'h000;
      dataOut <= 1'b0;
      dataOutEn <= 1'b0;
      eocOut <= 1'b1;
      sampling <= 1'b0;
      muxAddr <= 4'h0;
    end else begin
      csPrev_r <= csSync;
      sclkPrev_r <= sclkSync;
      startConv_r <= 1'b0;
      if (convDone) begin
        lastResult_r <= convResult;
        eocOut <= 1'b1; // [RULE_12]
      end
      if (csFall) begin
        active_r <= 1'b1; // [RULE_01]
        setupCnt_r <= SETUP_CYCLES[`SAC_SETUP_CNT_W-1:0];
        riseCnt_r <= 4'h0; // [RULE_01]
        fallCnt_r <= 4'h0; // [RULE_01]
        sampling <= 1'b0;
        dataOutEn <= 1'b1; // [RULE_05]
        outShift_r <= orderedLast;
        dataOut <= orderedLast[11]; // [RULE_06]
      end else if (csRise) begin
        active_r <= 1'b0; // [RULE_02]
        dataOutEn <= 1'b0; // [RULE_05]
        sampling <= 1'b0;
      end else if (active_r) begin
        if (setupCnt_r != {`SAC_SETUP_CNT_W{1'b0}})
          setupCnt_r <= setupCnt_r - 7'h01;
        if (sclkRise && riseCnt_r < `SAC_IN_BITS) begin
          inShift_r <= {inShift_r[6:0], dinSync}; // [RULE_03] [RULE_04]
          riseCnt_r <= riseCnt_r + 4'h1;
          if (riseCnt_r == `SAC_ADDR_BITS - 1)
            muxAddr <= {inShift_r[2:0], dinSync}; // [RULE_04]
          if (riseCnt_r == `SAC_IN_BITS - 1)
            lsbFirst_r <= inShift_r[`SAC_IN_ORDER_BIT-1];
        end
        if (sclkFall && fallCnt_r < `SAC_FRAME_CLKS) begin
          fallCnt_r <= fallCnt_r + 4'h1;
          outShift_r <= {outShift_r[10:0], 1'b0}; // [RULE_08]
          dataOut <= outShift_r[10]; // [RULE_07]
          if (fallCnt_r == `SAC_SAMPLE_FALL - 1)
            sampling <= 1'b1; // [RULE_09]
          if (fallCnt_r == `SAC_FRAME_CLKS - 1) begin
            sampling <= 1'b0; // [RULE_09]
            startConv_r <= 1'b1; // [RULE_10] [RULE_14]
            convChan_r <= muxAddr;
            eocOut <= 1'b0; // [RULE_11]
          end
        end
      end
    end
  end
endmodule // sac_port

// >>> logic/sac_regs.vh
// Constants for the serial converter control port.
// Assumes inclusion by the port logic; definitions only.
`ifndef SAC_REGS_VH
`define SAC_REGS_VH
// =============================================
// Frame layout
`define SAC_ADDR_BITS 4
`define SAC_IN_BITS 8
`define SAC_RES_BITS 12
`define SAC_FRAME_CLKS 12
`define SAC_SAMPLE_FALL 4
// =============================================
// Input register fields
`define SAC_IN_ADDR_HI 7
`define SAC_IN_ADDR_LO 4
`define SAC_IN_ORDER_BIT 1
// =============================================
// Channel map
`define SAC_NUM_CHAN 14
`define SAC_NUM_ANALOG 11
// =============================================
// Timing
`define SAC_CLK_NS 20
`define SAC_CONV_NS 10000
`define SAC_CONV_CYCLES (`SAC_CONV_NS / `SAC_CLK_NS)
`define SAC_CS_SETUP_NS 1425
`define SAC_CS_SETUP_CYCLES ((`SAC_CS_SETUP_NS + `SAC_CLK_NS - 1) / `SAC_CLK_NS)
`define SAC_CONV_CNT_W 10
`define SAC_SETUP_CNT_W 7
`endif

// >>> logic/sac_sync.v
// Two-flop synchroniser for one pin level.
// Assumes the pin is asynchronous to ref_clk.
`timescale 1ns/1ns
module sac_sync #(
  parameter IDLE = 1'b0
) (
  input wire ref_clk,
  input wire resetn,
  input wire pinIn,
  output reg syncOut
);
  reg meta_r;
  always @(posedge ref_clk) begin
    if (!resetn) begin
      meta_r <= IDLE;
      syncOut <= IDLE;
    end else begin
      meta_r <= pinIn;
      syncOut <= meta_r;
    end
  end
endmodule // sac_sync

// >>> logic/sac_conv.v
// Conversion timer and result model: runs on ref_clk alone.
// Assumes a one-cycle start pulse with a channel code.
`timescale 1ns/1ns
`include "sac_regs.vh"
module sac_conv #(
  parameter CONV_CYCLES = `SAC_CONV_CYCLES
) (
  input wire ref_clk,
  input wire resetn,
  input wire start,
  input wire [3:0] chanSel,
  input wire [`SAC_NUM_ANALOG*12-1:0] analogIn,
  output reg busy,
  output reg done,
  output reg [11:0] result
);
  reg [`SAC_CONV_CNT_W-1:0] cnt_r;
  reg [3:0] chan_r;
  // =============================================
  // Channel decode
  function [11:0] pick;
    input [3:0] ch;
    input [`SAC_NUM_ANALOG*12-1:0] ain;
    begin
      if (ch < `SAC_NUM_ANALOG)
        pick = ain[ch*12 +: 12];
      else if (ch == 4'hb)
        pick = 12'h800;
      else if (ch == 4'hc)
        pick = 12'h000;
      else if (ch == 4'hd)
        pick = 12'hfff;
      else
        pick = 12'h000;
    end
  endfunction
  always @(posedge ref_clk) begin
    if (!resetn) begin
      busy <= 1'b0;
      done <= 1'b0;
      cnt_r <= {`SAC_CONV_CNT_W{1'b0}};
      chan_r <= 4'h0;
      result <= 12'h000;
    end else begin
      done <= 1'b0;
      if (start) begin
        busy <= 1'b1;
        chan_r <= chanSel;
        cnt_r <= CONV_CYCLES[`SAC_CONV_CNT_W-1:0] - 10'h001;
      end else if (busy) begin
        if (cnt_r == {`SAC_CONV_CNT_W{1'b0}}) begin
          busy <= 1'b0;
          done <= 1'b1;
          result <= pick(chan_r, analogIn);
        end else
          cnt_r <= cnt_r - 10'h001;
      end
    end
  end
endmodule // sac_conv

// >>> verif/sac_port_monitor.sv
// Pin-level checker for the converter port.
// Assumes bind onto sac_port.
`timescale 1ns/1ns
`include "sac_regs.vh"
module sac_port_monitor #(
  parameter CONV_CYCLES = 500
) (
  input wire ref_clk,
  input wire resetn,
  input wire csN,
  input wire shiftClk,
  input wire dataIn,
  input wire [`SAC_NUM_ANALOG*12-1:0] analogChannelInputs,
  input wire dataOut,
  input wire dataOutEn,
  input wire eocOut,
  input wire sampling,
  input wire [3:0] muxAddr
);
  localparam int LIM = CONV_CYCLES + 8;
  // ==============================
  // Pin relations
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  a_hiz_desel: assert property (csN [*5] |-> !dataOutEn) else $error("out driven");
  a_drive_sel: assert property ($fell(csN) |-> ##[2:5] dataOutEn) else $error("out not driven");
  a_out_hold_high: assert property ($rose(shiftClk) |-> ##2 $stable(dataOut) [*3]) else $error("out moved");
  a_mux_in_frame: assert property ($changed(muxAddr) |-> !csN && dataOutEn) else $error("addr moved");
  a_samp_in_frame: assert property ($rose(sampling) |-> !csN && dataOutEn) else $error("bad sample");
  a_eoc_after_samp: assert property ($fell(eocOut) |-> $past(sampling) || $past(sampling, 2)) else $error("eoc");
  a_eoc_min_low: assert property ($fell(eocOut) |-> !eocOut [*8]) else $error("eoc short");
  a_eoc_bound: assert property ($fell(eocOut) |-> ##[1:LIM] eocOut) else $error("eoc late");
endmodule // sac_port_monitor

bind sac_port sac_port_monitor #(.CONV_CYCLES(CONV_CYCLES)) i_mon (.ref_clk(ref_clk), .resetn(resetn),
  .csN(csN), .shiftClk(shiftClk), .dataIn(dataIn), .analogChannelInputs(analogChannelInputs),
  .dataOut(dataOut), .dataOutEn(dataOutEn), .eocOut(eocOut), .sampling(sampling), .muxAddr(muxAddr));

// >>> verif/sac_host_model.sv
// Host serial port model for the converter pins.
// Assumes ref_clk of 20 ns; shift clock of 8 cycles.
`timescale 1ns/1ns
module sac_host_model (
  input wire ref_clk,
  input wire dataOut,
  input wire dataOutEn,
  output reg csN,
  output reg shiftClk,
  output reg dataIn
);
  reg lastBit;
  wire pinLvl = dataOutEn ? dataOut : ~lastBit;
  initial begin
    csN = 1'b1;
    shiftClk = 1'b0;
    dataIn = 1'b0;
    lastBit = 1'b0;
  end
  always @(posedge ref_clk) lastBit <= pinLvl;
  // ==============================
  // One frame of n shift pulses
  task frame(input [7:0] cmd, input integer n, output [11:0] rd);
    integer i;
    begin
      rd = 12'h000;
      csN <= 1'b0;
      dataIn <= cmd[7];
      repeat (12) @(posedge ref_clk);
      for (i = 0; i < n; i = i + 1) begin
        repeat (4) @(posedge ref_clk);
        shiftClk <= 1'b1;
        repeat (4) @(posedge ref_clk);
        rd = {rd[10:0], pinLvl};
        shiftClk <= 1'b0;
        dataIn <= (i < 7) ? cmd[6 - i] : 1'b0;
      end
      repeat (5) @(posedge ref_clk);
      csN <= 1'b1;
      repeat (8) @(posedge ref_clk);
    end
  endtask
endmodule // sac_host_model

// >>> verif/tb_sac_port.sv
// Self-checking bench for sac_port.
// Assumes sac_host_model drives the serial pins.
`timescale 1ns/1ns
`include "sac_regs.vh"
module tb_sac_port;
  reg ref_clk = 1'b0;
  reg resetn = 1'b0;
  reg [`SAC_NUM_ANALOG*12-1:0] ain;
  wire csN, shiftClk, dataIn, dataOut, dataOutEn, eocOut, sampling;
  wire [3:0] muxAddr;
  integer nMismatch = 0;
  integer checksDone = 0;
  integer k;
  reg [11:0] rd;
  sac_port #(.CONV_CYCLES(20), .SETUP_CYCLES(4)) i_dut (.ref_clk(ref_clk), .resetn(resetn), .csN(csN),
    .shiftClk(shiftClk), .dataIn(dataIn), .analogChannelInputs(ain), .dataOut(dataOut),
    .dataOutEn(dataOutEn), .eocOut(eocOut), .sampling(sampling), .muxAddr(muxAddr));
  sac_host_model i_host (.ref_clk(ref_clk), .dataOut(dataOut), .dataOutEn(dataOutEn), .csN(csN),
    .shiftClk(shiftClk), .dataIn(dataIn));
  initial forever #10 ref_clk = ~ref_clk;
  // ==============================
  // Helpers
  task chk(input [11:0] got, input [11:0] exp);
    begin
      checksDone = checksDone + 1;
      if (got !== exp) begin
        nMismatch = nMismatch + 1;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  function [11:0] chVal(input integer c);
    chVal = (c < 11) ? ain[c*12 +: 12] : (c == 11) ? 12'h800 : (c == 13) ? 12'hfff : 12'h000;
  endfunction
  task conv(input [7:0] cmd, input [11:0] exp);
    integer w;
    begin
      i_host.frame(cmd, 12, rd);
      chk(rd, exp);
      chk({8'h00, muxAddr}, {8'h00, cmd[7:4]});
      chk({11'h000, dataOutEn}, 12'h000);
      chk({11'h000, sampling}, 12'h000);
      chk({11'h000, eocOut}, 12'h000);
      w = 0;
      while (eocOut !== 1'b1 && w < 40) begin
        @(posedge ref_clk);
        w = w + 1;
      end
      chk({11'h000, eocOut}, 12'h001);
    end
  endtask
  task end_of_test;
    begin
      $display("mismatches %0d checks %0d", nMismatch, checksDone);
      if (nMismatch == 0 && checksDone > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
    end
  endtask
  // ==============================
  // Scenarios
  task t_channels;
    begin
      conv(8'h50, 12'h000);
      for (k = 0; k < 16; k = k + 1) conv({k[3:0], 4'h0}, chVal((k == 0) ? 5 : k - 1));
    end
  endtask
  task t_lsb_first;
    begin
      conv(8'hb2, 12'h000);
      conv(8'h00, 12'h001);
    end
  endtask
  task t_abort;
    begin
      i_host.frame(8'h30, 5, rd);
      repeat (30) @(posedge ref_clk);
      chk({11'h000, eocOut}, 12'h001);
      conv(8'h00, chVal(0));
    end
  endtask
  initial begin
    for (k = 0; k < 11; k = k + 1) ain[k*12 +: 12] = {k[3:0], ~k[3:0], 4'h5};
    repeat (12) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (4) @(posedge ref_clk);
    t_channels;
    t_lsb_first;
    t_abort;
    end_of_test;
  end
  initial begin
    #200000;
    nMismatch = nMismatch + 1;
    end_of_test;
  end
endmodule // tb_sac_port
